// *** hdl/rom_decode_pkg.sv ***
package rom_decode_pkg;

  // ****************************************
  // register map (byte addresses on apb)
  // ****************************************
  localparam logic [15:0] CSR_ADDR    = 16'hfe00;
  localparam logic [15:0] STATUS_ADDR = 16'hfe04;
  localparam logic [15:0] STRAP_ADDR  = 16'hfe08;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int          CSR_W0_LSB   = 0;
  localparam int          CSR_W1_LSB   = 8;
  localparam int          CSR_FIELD_W  = 5;
  localparam int          CSR_WDIS_BIT = 15;
  localparam logic [15:0] CSR_RESET    = 16'h0000;
  localparam logic [15:0] CSR_RW_MASK  = 16'h1f1f;

  // ****************************************
  // system bus address layout
  // ****************************************
  localparam int          SYS_AW       = 18;
  localparam int          BANK_LSB     = 13;
  localparam int          BANK_W       = 5;
  localparam int          WIN_BLK_LSB  = 12;
  localparam int          WIN_BLK_W    = 6;
  localparam int          WIN_SEL_BIT  = 11;
  localparam int          SEG_LSB      = 11;
  localparam int          CHIP_LOG_1K  = 10;
  localparam logic [5:0]  WIN_BASE_REC = 6'h3e;

  // ****************************************
  // chip size straps
  // ****************************************
  typedef enum logic [1:0] {
    SZ_1K = 2'b00,
    SZ_2K = 2'b01,
    SZ_4K = 2'b10
  } chip_size_t;

  localparam int MAX_CHIPS  = 16;
  localparam int CS_COUNT   = 8;

endpackage

// *** hdl/sel_if.sv ***
`timescale 1ns/1ps
interface sel_if;
  import rom_decode_pkg::*;
  logic [4:0] src;
  chip_size_t size;
  logic [7:0] cs;
  logic [1:0] ext;
  modport drv (output src, output size, input cs, input ext);
  modport dec (input src, input size, output cs, output ext);
endinterface

// *** hdl/chip_sel_decode.sv ***
`timescale 1ns/1ps
module chip_sel_decode
  import rom_decode_pkg::*;
(
  sel_if.dec s
);

  // ****************************************
  // selector split and one-of-eight decode
  // ****************************************
  logic [2:0] top3;

  always_comb begin
    unique case (s.size)
      SZ_2K: begin
        top3  = s.src[3:1];
        s.ext = {1'b0, s.src[0]};
      end
      SZ_4K: begin
        top3  = s.src[4:2];
        s.ext = s.src[1:0];
      end
      default: begin
        top3  = s.src[2:0];
        s.ext = 2'b00;
      end
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < CS_COUNT; g++) begin : g_cs
      assign s.cs[g] = (top3 == 3'(g));
    end
  endgenerate

endmodule

// *** hdl/window_match.sv ***
`timescale 1ns/1ps
module window_match
  import rom_decode_pkg::*;
(
  input  wire logic [SYS_AW-1:0]    addr,
  input  wire logic [WIN_BLK_W-1:0] win_base,
  input  wire logic [BANK_W-1:0]    bank,
  input  wire logic [18:0]          range_bytes,
  output logic                      win_hit,
  output logic                      dir_hit
);

  // ****************************************
  // address comparators
  // ****************************************
  logic [18:0] offset;

  assign win_hit = (addr[SYS_AW-1:WIN_BLK_LSB] == win_base);
  assign offset  = {1'b0, addr} - {1'b0, bank, 13'h0000};
  assign dir_hit = (addr[SYS_AW-1:BANK_LSB] >= bank) && (offset < range_bytes);

endmodule

// *** hdl/rom_board_address_decode.sv ***
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module rom_board_address_decode
  import rom_decode_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              ce,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [15:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              sys_valid,
  input  wire logic [SYS_AW-1:0] sys_addr,
  input  wire logic              strap_direct_en,
  input  wire logic              strap_win_off,
  input  wire logic              strap_wdis_opt,
  input  wire logic [4:0]        strap_bank_inst,
  input  wire logic [5:0]        strap_win_inst,
  input  wire logic [1:0]        strap_chip_size,
  input  wire logic [4:0]        strap_chip_count,
  output logic [7:0]             rom_cs,
  output logic [1:0]             rom_ext,
  output logic [9:0]             rom_word_addr,
  output logic                   board_hit,
  output logic                   window_ref
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] csr;
    logic [31:0] rdata;
    logic [7:0]  cs;
    logic [1:0]  ext;
    logic [9:0]  waddr;
    logic        hit;
    logic        win;
    logic        last_dir;
    logic        last_win;
    logic [2:0]  last_set;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  sel_if sif ();

  // ****************************************
  // strap interpretation
  // ****************************************
  logic [BANK_W-1:0]    bank;
  logic [WIN_BLK_W-1:0] win_base;
  chip_size_t           csize;
  logic [4:0]           chips;
  logic [18:0]          range_bytes;
  logic                 win_allowed;
  logic                 win_raw;
  logic                 dir_raw;
  logic                 win_hit;
  logic                 dir_hit;
  logic [4:0]           field;
  logic [4:0]           field_mask;

  assign bank     = ~strap_bank_inst;
  assign win_base = ~strap_win_inst;

  always_comb begin
    unique case (strap_chip_size)
      2'b01:   csize = SZ_2K;
      2'b10:   csize = SZ_4K;
      default: csize = SZ_1K;
    endcase
  end

  // chip count above sixteen is clamped
  assign chips       = (strap_chip_count > 5'(MAX_CHIPS)) ? 5'(MAX_CHIPS) : strap_chip_count;
  assign range_bytes = 19'(chips) << (CHIP_LOG_1K + int'(csize));

  window_match u_match (
    .addr        (sys_addr),
    .win_base    (win_base),
    .bank        (bank),
    .range_bytes (range_bytes),
    .win_hit     (win_raw),
    .dir_hit     (dir_raw)
  );

  // bit 15 only matters when the disable option is strapped
  // bit 15 lets software silence a board that shares the block
  assign win_allowed = !strap_win_off && !(strap_wdis_opt && st_r.csr[CSR_WDIS_BIT]);
  assign win_hit     = sys_valid && win_raw && win_allowed;
  assign dir_hit     = sys_valid && dir_raw && strap_direct_en && !win_hit;

  // ****************************************
  // selector source
  // ****************************************
  always_comb begin
    unique case (csize)
      SZ_2K:   field_mask = 5'h0f;
      SZ_4K:   field_mask = 5'h1f;
      default: field_mask = 5'h07;
    endcase
  end

  // window 1 is the upper 2K of the block
  assign field = sys_addr[WIN_SEL_BIT] ? st_r.csr[CSR_W1_LSB +: CSR_FIELD_W]
                                       : st_r.csr[CSR_W0_LSB +: CSR_FIELD_W];

  always_comb begin
    if (win_hit) begin
      sif.src = field & field_mask;
    end else begin
      sif.src = sys_addr[SEG_LSB +: 5];
    end
  end
  assign sif.size = csize;

  chip_sel_decode u_dec (
    .s (sif)
  );

  // ****************************************
  // apb decode
  // ****************************************
  logic        setup;
  logic        access;
  logic        sel_csr;
  logic        sel_stat;
  logic        sel_strap;
  logic        mapped;
  logic [15:0] wmask;
  logic [15:0] rw_mask;
  logic [31:0] rd_val;

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign sel_csr   = (paddr == CSR_ADDR);
  assign sel_stat  = (paddr == STATUS_ADDR);
  assign sel_strap = (paddr == STRAP_ADDR);
  assign mapped    = sel_csr || sel_stat || sel_strap;
  assign rw_mask   = strap_wdis_opt ? (CSR_RW_MASK | 16'h8000) : CSR_RW_MASK;
  assign wmask     = {{8{pstrb[1]}}, {8{pstrb[0]}}} & rw_mask;

  assign pready  = 1'b1;
  // only the control register takes written data
  assign pslverr = access && (!mapped || (pwrite && !sel_csr));
  assign prdata  = st_r.rdata;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (sel_csr) begin
      rd_val = {16'h0000, st_r.csr};
    end else if (sel_stat) begin
      rd_val = {24'h0, 1'b0, st_r.last_set, 2'b00, st_r.last_win, st_r.last_dir};
    end else if (sel_strap) begin
      rd_val = {8'h0, 3'b000, chips, 2'b00, win_base, 3'b000, bank};
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (setup && !pwrite) begin
      st_nxt.rdata = rd_val;
    end
    if (access && pwrite && sel_csr) begin
      st_nxt.csr = (st_r.csr & ~wmask) | (pwdata[15:0] & wmask);
    end
    st_nxt.hit   = win_hit || dir_hit;
    st_nxt.win   = win_hit;
    st_nxt.cs    = (win_hit || dir_hit) ? sif.cs : 8'h00;
    st_nxt.ext   = (win_hit || dir_hit) ? sif.ext : 2'b00;
    st_nxt.waddr = sys_addr[10:1];
    if (win_hit || dir_hit) begin
      st_nxt.last_dir = dir_hit;
      st_nxt.last_win = win_hit;
      st_nxt.last_set = 3'(sif.src >> int'(csize));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.csr <= CSR_RESET;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rom_cs        = st_r.cs;
  assign rom_ext       = st_r.ext;
  assign rom_word_addr = st_r.waddr;
  assign board_hit     = st_r.hit;
  assign window_ref    = st_r.win;

endmodule

// *** tb/rom_decode_props.sv ***
`timescale 1ns/1ps
module rom_decode_props
  import rom_decode_pkg::*;
(
  input wire logic              pclk, presetn, ce, psel, penable, pwrite, pslverr,
  input wire logic [15:0]       paddr,
  input wire logic              sys_valid, strap_win_off, strap_wdis_opt, board_hit, window_ref,
  input wire logic [SYS_AW-1:0] sys_addr,
  input wire logic [4:0]        strap_bank_inst,
  input wire logic [5:0]        strap_win_inst,
  input wire logic [7:0]        rom_cs,
  input wire logic [9:0]        rom_word_addr
);
  // ****************************************
  // decode checks
  // ****************************************
  logic       wh;
  logic [9:0] wa;
  assign wh = sys_addr[17:12] == ~strap_win_inst;
  assign wa = sys_addr[10:1];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cs_one_hot: assert property (board_hit |-> $onehot(rom_cs))
    else $error("chip select not one-hot");
  a_cs_idle: assert property (!board_hit |-> rom_cs == 8'h00)
    else $error("chip select without hit");
  a_idle_no_hit: assert property (ce && !sys_valid |=> !board_hit)
    else $error("hit without address");
  a_win_answer: assert property (ce && sys_valid && wh && !strap_win_off && !strap_wdis_opt
    |=> board_hit && window_ref)
    else $error("window not answered");
  a_win_refused: assert property (ce && sys_valid && strap_win_off |=> !window_ref)
    else $error("window answered while off");
  a_below_base: assert property (ce && sys_valid && !wh && sys_addr[17:13] < ~strap_bank_inst
    |=> !board_hit)
    else $error("hit below base");
  a_word_lines: assert property (ce && sys_valid |=> rom_word_addr == $past(wa))
    else $error("chip address lines wrong");
  a_ro_refused: assert property (psel && penable && pwrite && paddr != CSR_ADDR |-> pslverr)
    else $error("write to read-only place accepted");
endmodule

bind rom_board_address_decode rom_decode_props i_props (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pslverr(pslverr), .paddr(paddr), .sys_valid(sys_valid), .strap_win_off(strap_win_off),
  .strap_wdis_opt(strap_wdis_opt), .board_hit(board_hit), .window_ref(window_ref),
  .sys_addr(sys_addr), .strap_bank_inst(strap_bank_inst), .strap_win_inst(strap_win_inst),
  .rom_cs(rom_cs), .rom_word_addr(rom_word_addr)
);

// *** tb/sys_host_model.sv ***
`timescale 1ns/1ps
module sys_host_model
  import rom_decode_pkg::*;
(
  input  wire logic        pclk,
  output logic             sys_valid,
  output logic [SYS_AW-1:0] sys_addr
);
  initial begin
    sys_valid = 1'b0;
    sys_addr  = '0;
  end
  // ****************************************
  // one address cycle, line inverted once released
  // ****************************************
  task issue(input logic [SYS_AW-1:0] a);
    @(posedge pclk);
    sys_valid <= 1'b1;
    sys_addr  <= a;
    @(posedge pclk);
    sys_valid <= 1'b0;
    sys_addr  <= ~a;
  endtask
endmodule

// *** tb/rom_board_address_decode_bench.sv ***
`timescale 1ns/1ps
module rom_board_address_decode_bench;
  import rom_decode_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        sys_valid, board_hit, window_ref, dir_en, win_off, wdis;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [17:0] sys_addr;
  logic [4:0]  bank_i, cnt;
  logic [5:0]  win_i;
  logic [1:0]  sz, rom_ext;
  logic [7:0]  rom_cs;
  logic [9:0]  rom_word_addr;
  int          fails, samples_checked, src;

  rom_board_address_decode i_dut (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .sys_valid(sys_valid), .sys_addr(sys_addr), .strap_direct_en(dir_en),
    .strap_win_off(win_off), .strap_wdis_opt(wdis), .strap_bank_inst(bank_i),
    .strap_win_inst(win_i), .strap_chip_size(sz), .strap_chip_count(cnt), .rom_cs(rom_cs),
    .rom_ext(rom_ext), .rom_word_addr(rom_word_addr), .board_hit(board_hit), .window_ref(window_ref)
  );
  sys_host_model i_host (.pclk(pclk), .sys_valid(sys_valid), .sys_addr(sys_addr));

  // ****************************************
  // tasks
  // ****************************************
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= 4'h3;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    chk(pready, 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task win(input logic [17:0] a, input logic h, input logic [7:0] c, input logic [1:0] x);
    i_host.issue(a);
    #1;
    chk(board_hit, h);
    chk(rom_cs, c);
    chk(window_ref, h && (a[17:12] == ~win_i));
    chk(rom_word_addr, 32'(a[10:1]));
    if (h) chk(rom_ext, x);
  endtask
  task sel(input logic [17:0] a, input int f, input int s);
    src = f & ((8 << s) - 1);
    win(a, 1'b1, 8'h01 << (src >> s), src & ((1 << s) - 1));
  endtask
  task wrap_up;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ****************************************
  // sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {dir_en, win_off, wdis, sz} = '0;
    bank_i = 5'h1c;
    win_i  = 6'h01;
    cnt    = 5'h10;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, CSR_ADDR, 32'hffffffff);
    chk(er, 1'b0);
    apb(1'b0, CSR_ADDR, 32'h0);
    chk(rd, 32'h00001f1f);
    apb(1'b1, STATUS_ADDR, 32'h1);
    chk(er, 1'b1);
    apb(1'b0, 16'hfe10, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, CSR_ADDR, 32'h00000a13);
    for (int s = 0; s < 3; s++) begin
      sz <= 2'(s);
      sel(18'h3e000, 'h13, s);
      sel(18'h3e800, 'h0a, s);
    end
    win_off <= 1'b1;
    win(18'h3e000, 1'b0, 8'h00, 2'h0);
    win_off <= 1'b0;
    wdis    <= 1'b1;
    apb(1'b1, CSR_ADDR, 32'h00008013);
    apb(1'b0, CSR_ADDR, 32'h0);
    chk(rd, 32'h00008013);
    win(18'h3e000, 1'b0, 8'h00, 2'h0);
    wdis   <= 1'b0;
    dir_en <= 1'b1;
    sz     <= 2'h1;
    win(18'h07800, 1'b1, 8'h80, 2'h1);
    win(18'h05fff, 1'b0, 8'h00, 2'h0);
    win(18'h0dfff, 1'b1, 8'h20, 2'h1);
    win(18'h0e000, 1'b0, 8'h00, 2'h0);
    sz  <= 2'h0;
    cnt <= 5'h02;
    win(18'h067ff, 1'b1, 8'h10, 2'h0);
    win(18'h06800, 1'b0, 8'h00, 2'h0);
    wrap_up;
  end
endmodule
